// *** rtl/sdc_codec.sv ***
/*
 * Digital datapath of a single-channel sigma-delta voice codec: sinc3 decimator, sinc3
 * interpolator with bypass, DAC digital modulator, serial master port and APB control registers.
 * Assumes pclk is the divided master clock, gated by ce, and that adc_bit and ser_din arrive
 * asynchronously from pins.
 */
// Behaviour
// - Modulator bitstream is taken once every eight divided master clock cycles.
// - Decimator is sinc3 lowering rate to clock over M of 256 to 2048.
// - Decimator response is cube of comb over N, result grown to 15 bits.
// - ADC words are 15-bit two's complement; remaining bit is the control flag in mixed mode, a sign copy otherwise.
// - DAC samples are two's complement, 0x7FFF top and 0x8000 bottom.
// - Interpolator is sinc3 with same N, raising 16-bit samples to clock over eight.
// - One DAC sample per period; missing sample reuses the previous value.
// - Interpolator bypass feeds DAC samples straight to the modulator.
// - DAC modulator makes a one-bit stream at clock over eight.
// - Three-bit output gain code selects +6 dB down to -15 dB.
// - Mute bit silences the analog output.
// - Reference output is enabled only while its enable bit is set.
// - Serial words shift most significant bit first at the serial clock.
// - Codec always starts serial transfers as master; host is slave.
// - Up to eight codecs may be cascaded on one host port.
// - Mode bit clear: frames write control registers, contents may be read back.
// - Mode bit set, mixed off: every frame is DAC data, only ADC returned.
// - Mode and mixed set: frame MSB selects control or data, 15-bit resolution.
// - Sample rate code 00 to 11 selects clock over 2048, 1024, 512, 256.
`timescale 1ns/100ps
module sdc_codec #(
  parameter int ACC_W = 26,
  parameter int INT_W = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_bit,
  output logic dac_bit,
  output logic codec_serial_clock,
  output logic ser_fsync,
  output logic ser_dout,
  input wire logic ser_din,
  output logic [2:0] out_gain_sel,
  output logic out_mute,
  output logic ref_out_enable,
  output logic interp_bypass
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [2:0] SDC_IDX_A = sdc_pkg::SDC_IDX_A;
  localparam logic [2:0] SDC_IDX_B = sdc_pkg::SDC_IDX_B;
  localparam logic [2:0] SDC_IDX_C = sdc_pkg::SDC_IDX_C;
  localparam logic [2:0] SDC_IDX_D = sdc_pkg::SDC_IDX_D;
  localparam logic [2:0] SDC_IDX_E = sdc_pkg::SDC_IDX_E;
  logic [7:0] ctrl_r [sdc_pkg::SDC_NUM_CTRL];
  logic [7:0] ctrl_nxt [sdc_pkg::SDC_NUM_CTRL];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic adc_m_r, adc_s_r, din_m_r, din_s_r;
  logic [2:0] mod_cnt_r, mod_cnt_nxt;
  logic [7:0] samp_cnt_r, samp_cnt_nxt;
  logic signed [ACC_W-1:0] di_r [3];
  logic signed [ACC_W-1:0] di_nxt [3];
  logic signed [ACC_W-1:0] dd_r [3];
  logic signed [ACC_W-1:0] dd_nxt [3];
  logic signed [14:0] adc_r, adc_nxt;
  logic signed [18:0] id_r [3];
  logic signed [18:0] id_nxt [3];
  logic signed [INT_W-1:0] ii_r [3];
  logic signed [INT_W-1:0] ii_nxt [3];
  logic [15:0] dac_hold_r, dac_hold_nxt;
  logic [16:0] dsm_r, dsm_nxt;
  logic dac_bit_r, dac_bit_nxt;
  sdc_pkg::sdc_ser_e sp_r, sp_nxt;
  logic [3:0] div_r, div_nxt, bit_r, bit_nxt;
  logic [2:0] word_r, word_nxt;
  logic [15:0] sh_r, sh_nxt, rdback_r, rdback_nxt;
  logic sclk_r, sclk_nxt, fs_r, fs_nxt, sdo_r, sdo_nxt;

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  logic strobe, samp_evt, mode_data, mode_mixed;
  logic [3:0] log2n, sclk_per, sclk_half;
  logic [7:0] n_m1;
  logic [2:0] dev_m1;
  logic [1:0] srate, sclk_code;

  always_comb begin
    mode_data = ctrl_r[SDC_IDX_A][sdc_pkg::SDC_A_MODE_BIT];
    mode_mixed = ctrl_r[SDC_IDX_A][sdc_pkg::SDC_A_MIXED_BIT];
    dev_m1 = ctrl_r[SDC_IDX_A][sdc_pkg::SDC_A_DEVCNT_LSB +: 3];
    srate = ctrl_r[SDC_IDX_B][sdc_pkg::SDC_B_SRATE_LSB +: 2];
    sclk_code = ctrl_r[SDC_IDX_B][sdc_pkg::SDC_B_SCLK_LSB +: 2];
    log2n = sdc_pkg::SDC_LOG2N_SLOWEST - {2'h0, srate};
    n_m1 = 8'((9'h001 << log2n) - 9'h001);
    strobe = (mod_cnt_r == sdc_pkg::SDC_MOD_DIV_M1);
    samp_evt = strobe && (samp_cnt_r == n_m1);
    sclk_per = sdc_pkg::SDC_MOD_DIV >> sclk_code;
    if (sclk_per < sdc_pkg::SDC_SCLK_MIN) begin
      sclk_per = sdc_pkg::SDC_SCLK_MIN;
    end
    sclk_half = sclk_per >> 1;
  end

  // ****************************************************************
  // Sample timing and decimator
  // ****************************************************************
  logic signed [ACC_W-1:0] din_pm, c1, c2, c3, dsh;
  logic [3:0] dshift;

  always_comb begin
    mod_cnt_nxt = mod_cnt_r + 3'h1;
    samp_cnt_nxt = samp_cnt_r;
    di_nxt = di_r;
    dd_nxt = dd_r;
    adc_nxt = adc_r;
    din_pm = adc_s_r ? ACC_W'(1) : -ACC_W'(1);
    c1 = di_r[2] - dd_r[0];
    c2 = c1 - dd_r[1];
    c3 = c2 - dd_r[2];
    dshift = 4'((3 * log2n) - 14);
    dsh = c3 >>> dshift;
    if (strobe) begin
      samp_cnt_nxt = samp_evt ? 8'h00 : samp_cnt_r + 8'h01;
      di_nxt[0] = di_r[0] + din_pm;
      di_nxt[1] = di_r[1] + di_r[0];
      di_nxt[2] = di_r[2] + di_r[1];
    end
    if (samp_evt) begin
      dd_nxt[0] = di_r[2];
      dd_nxt[1] = c1;
      dd_nxt[2] = c2;
      if (dsh > ACC_W'(sdc_pkg::SDC_ADC_MAX)) begin
        adc_nxt = 15'(sdc_pkg::SDC_ADC_MAX);
      end else if (dsh < ACC_W'(sdc_pkg::SDC_ADC_MIN)) begin
        adc_nxt = 15'(sdc_pkg::SDC_ADC_MIN);
      end else begin
        adc_nxt = dsh[14:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_cnt_r <= 3'h0;
      samp_cnt_r <= 8'h00;
      di_r <= '{default: '0};
      dd_r <= '{default: '0};
      adc_r <= 15'h0000;
      adc_m_r <= 1'b0;
      adc_s_r <= 1'b0;
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
    end else if (ce) begin
      mod_cnt_r <= mod_cnt_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      di_r <= di_nxt;
      dd_r <= dd_nxt;
      adc_r <= adc_nxt;
      adc_m_r <= adc_bit;
      adc_s_r <= adc_m_r;
      din_m_r <= ser_din;
      din_s_r <= din_m_r;
    end
  end

  // ****************************************************************
  // Interpolator and DAC modulator
  // ****************************************************************
  logic signed [18:0] k1, k2, k3;
  logic signed [INT_W-1:0] iu, ish;
  logic signed [15:0] mod_in;

  always_comb begin
    id_nxt = id_r;
    ii_nxt = ii_r;
    dsm_nxt = dsm_r;
    dac_bit_nxt = dac_bit_r;
    k1 = 19'(signed'(dac_hold_r)) - id_r[0];
    k2 = k1 - id_r[1];
    k3 = k2 - id_r[2];
    iu = samp_evt ? INT_W'(k3) : '0;
    ish = ii_r[2] >>> {log2n, 1'b0};
    if (ish > INT_W'(sdc_pkg::SDC_DAC_MAX)) begin
      mod_in = 16'(sdc_pkg::SDC_DAC_MAX);
    end else if (ish < INT_W'(sdc_pkg::SDC_DAC_MIN)) begin
      mod_in = 16'(sdc_pkg::SDC_DAC_MIN);
    end else begin
      mod_in = ish[15:0];
    end
    if (interp_bypass) begin
      mod_in = dac_hold_r;
    end
    if (samp_evt) begin
      id_nxt[0] = 19'(signed'(dac_hold_r));
      id_nxt[1] = k1;
      id_nxt[2] = k2;
    end
    if (strobe) begin
      ii_nxt[0] = ii_r[0] + iu;
      ii_nxt[1] = ii_r[1] + ii_r[0];
      ii_nxt[2] = ii_r[2] + ii_r[1];
      dsm_nxt = {1'b0, dsm_r[15:0]} + {1'b0, ~mod_in[15], mod_in[14:0]};
      dac_bit_nxt = dsm_nxt[16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_r <= '{default: '0};
      ii_r <= '{default: '0};
      dsm_r <= 17'h00000;
      dac_bit_r <= 1'b0;
    end else if (ce) begin
      id_r <= id_nxt;
      ii_r <= ii_nxt;
      dsm_r <= dsm_nxt;
      dac_bit_r <= dac_bit_nxt;
    end
  end

  // ****************************************************************
  // Serial port, control registers and APB slave
  // ****************************************************************
  sdc_pkg::sdc_cw_s cw;
  logic done, is_ctrl, apb_acc, apb_wr;

  always_comb begin
    sp_nxt = sp_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    word_nxt = word_r;
    sh_nxt = sh_r;
    sclk_nxt = sclk_r;
    fs_nxt = 1'b0;
    sdo_nxt = sdo_r;
    rdback_nxt = rdback_r;
    dac_hold_nxt = dac_hold_r;
    ctrl_nxt = ctrl_r;
    done = 1'b0;
    case (sp_r)
      sdc_pkg::SDC_SP_IDLE: begin
        sclk_nxt = 1'b0;
        if (samp_evt) begin
          sp_nxt = sdc_pkg::SDC_SP_SHIFT;
          div_nxt = 4'h0;
          bit_nxt = 4'h0;
          word_nxt = 3'h0;
          if (!mode_data) begin
            sh_nxt = rdback_r;
          end else if (mode_mixed) begin
            sh_nxt = {1'b0, adc_nxt};
          end else begin
            sh_nxt = {adc_nxt[14], adc_nxt};
          end
        end
      end
      sdc_pkg::SDC_SP_SHIFT: begin
        div_nxt = (div_r == sclk_per - 4'h1) ? 4'h0 : div_r + 4'h1;
        if (div_r == 4'h0) begin
          sclk_nxt = 1'b1;
          sdo_nxt = sh_r[15];
          fs_nxt = (bit_r == 4'h0) && (word_r == 3'h0);
        end else if (div_r == sclk_half) begin
          sclk_nxt = 1'b0;
          sh_nxt = {sh_r[14:0], din_s_r};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == sdc_pkg::SDC_WORD_LAST) begin
            word_nxt = word_r + 3'h1;
            if (word_r == dev_m1) begin
              done = 1'b1;
              sp_nxt = sdc_pkg::SDC_SP_IDLE;
            end
          end
        end
      end
      default: sp_nxt = sdc_pkg::SDC_SP_IDLE;
    endcase
    cw = sh_nxt;
    is_ctrl = !mode_data || (mode_mixed && cw.ctrl);
    if (done && is_ctrl) begin
      if (cw.rd && cw.addr < 3'(sdc_pkg::SDC_NUM_CTRL)) begin
        rdback_nxt = {1'b1, 3'h0, 1'b1, cw.addr, ctrl_r[cw.addr]};
      end else if (cw.addr < 3'(sdc_pkg::SDC_NUM_CTRL)) begin
        ctrl_nxt[cw.addr] = cw.data;
      end
    end else if (done) begin
      dac_hold_nxt = mode_mixed ? {cw[14:0], 1'b0} : cw;
    end
    apb_acc = psel && !penable;
    apb_wr = psel && penable && pready_r && pwrite;
    pready_nxt = apb_acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (apb_acc) begin
      case (paddr)
        sdc_pkg::SDC_OFF_CTRL_A: prdata_nxt = {24'h000000, ctrl_r[SDC_IDX_A]};
        sdc_pkg::SDC_OFF_CTRL_B: prdata_nxt = {24'h000000, ctrl_r[SDC_IDX_B]};
        sdc_pkg::SDC_OFF_CTRL_C: prdata_nxt = {24'h000000, ctrl_r[SDC_IDX_C]};
        sdc_pkg::SDC_OFF_CTRL_D: prdata_nxt = {24'h000000, ctrl_r[SDC_IDX_D]};
        sdc_pkg::SDC_OFF_CTRL_E: prdata_nxt = {24'h000000, ctrl_r[SDC_IDX_E]};
        sdc_pkg::SDC_OFF_ADC: prdata_nxt = {{17{adc_r[14]}}, adc_r};
        sdc_pkg::SDC_OFF_STATUS: prdata_nxt = {15'h0000, dac_hold_r, sp_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (apb_wr) begin
      case (paddr)
        sdc_pkg::SDC_OFF_CTRL_A: ctrl_nxt[SDC_IDX_A] = pwdata[7:0];
        sdc_pkg::SDC_OFF_CTRL_B: ctrl_nxt[SDC_IDX_B] = pwdata[7:0];
        sdc_pkg::SDC_OFF_CTRL_C: ctrl_nxt[SDC_IDX_C] = pwdata[7:0];
        sdc_pkg::SDC_OFF_CTRL_D: ctrl_nxt[SDC_IDX_D] = pwdata[7:0];
        sdc_pkg::SDC_OFF_CTRL_E: ctrl_nxt[SDC_IDX_E] = pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= sdc_pkg::SDC_SP_IDLE;
      div_r <= 4'h0;
      bit_r <= 4'h0;
      word_r <= 3'h0;
      sh_r <= 16'h0000;
      sclk_r <= 1'b0;
      fs_r <= 1'b0;
      sdo_r <= 1'b0;
      rdback_r <= 16'h0000;
      dac_hold_r <= 16'h0000;
      ctrl_r <= '{default: sdc_pkg::SDC_CTRL_RESET};
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      sp_r <= sp_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      word_r <= word_nxt;
      sh_r <= sh_nxt;
      sclk_r <= sclk_nxt;
      fs_r <= fs_nxt;
      sdo_r <= sdo_nxt;
      rdback_r <= rdback_nxt;
      dac_hold_r <= dac_hold_nxt;
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dac_bit = dac_bit_r;
  assign codec_serial_clock = sclk_r;
  assign ser_fsync = fs_r;
  assign ser_dout = sdo_r;
  assign out_gain_sel = ctrl_r[SDC_IDX_D][sdc_pkg::SDC_D_GAIN_LSB +: 3];
  assign out_mute = ctrl_r[SDC_IDX_D][sdc_pkg::SDC_D_MUTE_BIT];
  assign ref_out_enable = ctrl_r[SDC_IDX_C][sdc_pkg::SDC_C_BUFFERED_REF_PIN_BIT];
  assign interp_bypass = ctrl_r[SDC_IDX_E][sdc_pkg::SDC_E_INTERP_BYPASS_BIT];

endmodule : sdc_codec

// *** shared/sdc_pkg.sv ***
/*
 * Shared constants and types for the sigma-delta codec datapath: register offsets, control bit
 * positions, serial control word layout and serial port states.
 * Assumes a 32-bit APB register bus and one 16-bit serial word per device slot.
 */
package sdc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] SDC_OFF_CTRL_A = 12'h000;
  localparam logic [11:0] SDC_OFF_CTRL_B = 12'h004;
  localparam logic [11:0] SDC_OFF_CTRL_C = 12'h008;
  localparam logic [11:0] SDC_OFF_CTRL_D = 12'h00C;
  localparam logic [11:0] SDC_OFF_CTRL_E = 12'h010;
  localparam logic [11:0] SDC_OFF_ADC = 12'h014;
  localparam logic [11:0] SDC_OFF_STATUS = 12'h018;
  localparam int SDC_NUM_CTRL = 5;
  localparam logic [7:0] SDC_CTRL_RESET = 8'h00;

  // ****************************************************************
  // Control register index and field positions
  // ****************************************************************
  localparam logic [2:0] SDC_IDX_A = 3'h0;
  localparam logic [2:0] SDC_IDX_B = 3'h1;
  localparam logic [2:0] SDC_IDX_C = 3'h2;
  localparam logic [2:0] SDC_IDX_D = 3'h3;
  localparam logic [2:0] SDC_IDX_E = 3'h4;
  localparam int SDC_A_MODE_BIT = 0;
  localparam int SDC_A_MIXED_BIT = 1;
  localparam int SDC_A_DEVCNT_LSB = 2;
  localparam int SDC_B_SRATE_LSB = 0;
  localparam int SDC_B_SCLK_LSB = 2;
  localparam int SDC_C_BUFFERED_REF_PIN_BIT = 6;
  localparam int SDC_D_GAIN_LSB = 4;
  localparam int SDC_D_MUTE_BIT = 7;
  localparam int SDC_E_INTERP_BYPASS_BIT = 5;

  // ****************************************************************
  // Timing and datapath constants
  // ****************************************************************
  localparam logic [2:0] SDC_MOD_DIV_M1 = 3'h7;
  localparam logic [3:0] SDC_MOD_DIV = 4'h8;
  localparam logic [3:0] SDC_LOG2N_SLOWEST = 4'h8;
  localparam logic [3:0] SDC_SCLK_MIN = 4'h2;
  localparam logic [4:0] SDC_ADC_BITS = 5'hF;
  localparam logic [3:0] SDC_WORD_LAST = 4'hF;
  localparam int SDC_ADC_MAX = 16383;
  localparam int SDC_ADC_MIN = -16384;
  localparam int SDC_DAC_MAX = 32767;
  localparam int SDC_DAC_MIN = -32768;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic ctrl;
    logic [2:0] unused;
    logic rd;
    logic [2:0] addr;
    logic [7:0] data;
  } sdc_cw_s;

  typedef enum logic {SDC_SP_IDLE, SDC_SP_SHIFT} sdc_ser_e;

endpackage : sdc_pkg

// *** dv/sdc_codec_sva.sv ***
/* Checker for the codec datapath ports, bound to the design.
   Assumes ce held high and the serial clock divider at its reset code. */
`timescale 1ns/100ps
module sdc_codec_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dac_bit,
  input wire logic codec_serial_clock,
  input wire logic ser_fsync,
  input wire logic ser_dout,
  input wire logic [2:0] out_gain_sel,
  input wire logic out_mute,
  input wire logic ref_out_enable,
  input wire logic interp_bypass
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_ok;
  assign wr_ok = psel && penable && pwrite && pready && !pslverr;
  sequence sclk_high_s;
    codec_serial_clock [*4];
  endsequence
  sequence sclk_low_s;
    !codec_serial_clock;
  endsequence
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready late or long");
  apb_slverr_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  gain_write_a: assert property (wr_ok && paddr == sdc_pkg::SDC_OFF_CTRL_D |->
    ##2 out_gain_sel == $past(pwdata[6:4], 2)) else $error("gain code not applied");
  mute_write_a: assert property (wr_ok && paddr == sdc_pkg::SDC_OFF_CTRL_D |->
    ##2 out_mute == $past(pwdata[7], 2)) else $error("mute not applied");
  ref_write_a: assert property (wr_ok && paddr == sdc_pkg::SDC_OFF_CTRL_C |->
    ##2 ref_out_enable == $past(pwdata[6], 2)) else $error("ref enable not applied");
  bypass_write_a: assert property (wr_ok && paddr == sdc_pkg::SDC_OFF_CTRL_E |->
    ##2 interp_bypass == $past(pwdata[5], 2)) else $error("bypass not applied");
  dac_hold_a: assert property ($changed(dac_bit) |=> $stable(dac_bit) [*7])
    else $error("dac bit faster than one per eight");
  fsync_pulse_a: assert property (ser_fsync |-> $rose(codec_serial_clock) ##1 !ser_fsync)
    else $error("frame sync misplaced");
  sclk_rate_a: assert property ($rose(codec_serial_clock) |-> sclk_high_s ##1 sclk_low_s)
    else $error("serial clock phase wrong");
  dout_edge_a: assert property ($changed(ser_dout) |-> $rose(codec_serial_clock))
    else $error("serial data off the rising clock");
endmodule : sdc_codec_sva

bind sdc_codec sdc_codec_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .dac_bit(dac_bit),
  .codec_serial_clock(codec_serial_clock), .ser_fsync(ser_fsync), .ser_dout(ser_dout),
  .out_gain_sel(out_gain_sel), .out_mute(out_mute), .ref_out_enable(ref_out_enable),
  .interp_bypass(interp_bypass)
);

// *** dv/sdc_host_port.sv ***
/* Host serial port model in slave mode, facing the codec serial master.
   Assumes one codec on the link and a serial clock half period of four pclk. */
`timescale 1ns/100ps
module sdc_host_port (
  input wire logic pclk,
  input wire logic codec_serial_clock,
  input wire logic ser_fsync,
  input wire logic ser_dout,
  input wire logic [15:0] tx_word,
  output logic ser_din,
  output logic [15:0] rx_word,
  output logic [7:0] n_frames
);
  // ********
  // Slave shifter
  // ********
  logic sclk_prev_r = 1'b0;
  logic [4:0] bit_cnt_r = 5'h10;
  logic [4:0] idx;
  logic [15:0] shift_r = 16'h0000;
  logic din_r = 1'b0;
  logic [15:0] rx_r = 16'h0000;
  logic [7:0] nf_r = 8'h00;
  assign ser_din = din_r;
  assign rx_word = rx_r;
  assign n_frames = nf_r;
  always @(posedge pclk) begin
    sclk_prev_r <= codec_serial_clock;
    if (codec_serial_clock && !sclk_prev_r && (ser_fsync || bit_cnt_r != 5'h10)) begin
      idx = ser_fsync ? 5'h00 : bit_cnt_r;
      din_r <= tx_word[4'hF - idx[3:0]];
      shift_r <= {shift_r[14:0], ser_dout};
      bit_cnt_r <= idx + 5'h01;
      if (idx == 5'h0F) begin
        rx_r <= {shift_r[14:0], ser_dout};
        nf_r <= nf_r + 8'h01;
      end
    end else if (bit_cnt_r == 5'h10 && !codec_serial_clock && !sclk_prev_r) begin
      din_r <= ~din_r;
    end
  end
endmodule : sdc_host_port

// *** dv/sdc_codec_test.sv ***
/* Self-checking bench for the codec datapath.
   Assumes the host port model and the bound checker; ce and the modulator input are held high. */
`timescale 1ns/100ps
module sdc_codec_test;
  // ********
  // Signals and instances
  // ********
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, dac_bit, codec_serial_clock, ser_fsync, ser_dout, ser_din;
  logic out_mute, ref_out_enable, interp_bypass;
  logic [2:0] out_gain_sel;
  logic [15:0] tx_word = 16'h8700;
  logic [15:0] rx_word;
  logic [7:0] n_frames;
  int n_errors = 0;
  int checked = 0;
  initial begin
    forever #2 pclk = ~pclk;
  end
  sdc_codec dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_bit(1'b1), .dac_bit(dac_bit),
    .codec_serial_clock(codec_serial_clock), .ser_fsync(ser_fsync), .ser_dout(ser_dout),
    .ser_din(ser_din), .out_gain_sel(out_gain_sel), .out_mute(out_mute),
    .ref_out_enable(ref_out_enable), .interp_bypass(interp_bypass)
  );
  sdc_host_port host (
    .pclk(pclk), .codec_serial_clock(codec_serial_clock), .ser_fsync(ser_fsync),
    .ser_dout(ser_dout), .tx_word(tx_word), .ser_din(ser_din), .rx_word(rx_word),
    .n_frames(n_frames)
  );
  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rd_chk
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h5A5A5A, v});
    rd_chk(a, {24'h000000, v});
  endtask : wr_rd
  task automatic frames(input int k);
    logic [7:0] f;
    f = n_frames + 8'(k);
    for (int n = 0; n < 4096 * k && n_frames != f; n++) @(posedge pclk);
    check({24'h000000, n_frames}, {24'h000000, f});
  endtask : frames
  task automatic status_chk(input logic [15:0] exp);
    apb(1'b0, sdc_pkg::SDC_OFF_STATUS, 32'h00000000);
    check({16'h0000, rd[16:1]}, {16'h0000, exp});
  endtask : status_chk
  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    for (int i = 0; i < 5; i++) rd_chk(12'(4 * i), 32'h00000000);
    check({26'h0, interp_bypass, ref_out_enable, out_mute, out_gain_sel}, 32'h0);
    apb(1'b0, 12'h020, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
  endtask : t_reset
  task automatic t_fields();
    for (int g = 0; g < 8; g++) begin
      wr_rd(sdc_pkg::SDC_OFF_CTRL_D, {g[0], 3'(g), 4'h0});
      check({28'h0, out_mute, out_gain_sel}, {28'h0, g[0], 3'(g)});
    end
    wr_rd(sdc_pkg::SDC_OFF_CTRL_C, 8'h40);
    check({31'h0, ref_out_enable}, 32'h00000001);
    wr_rd(sdc_pkg::SDC_OFF_CTRL_C, 8'hBF);
    check({31'h0, ref_out_enable}, 32'h00000000);
    wr_rd(sdc_pkg::SDC_OFF_CTRL_E, 8'h20);
    check({31'h0, interp_bypass}, 32'h00000001);
    wr_rd(sdc_pkg::SDC_OFF_CTRL_E, 8'hDF);
    check({31'h0, interp_bypass}, 32'h00000000);
  endtask : t_fields
  task automatic t_rates();
    time t0;
    for (int c = 0; c < 4; c++) begin
      wr_rd(sdc_pkg::SDC_OFF_CTRL_B, 8'(c));
      frames(1);
      t0 = $time;
      frames(1);
      check(32'($time - t0), 32'((2048 >> c) * 4));
    end
  endtask : t_rates
  task automatic t_serial_ctrl();
    tx_word <= 16'h83A0;
    frames(2);
    check({28'h0, out_mute, out_gain_sel}, 32'h0000000A);
    rd_chk(sdc_pkg::SDC_OFF_CTRL_D, 32'h000000A0);
    tx_word <= 16'h8B00;
    frames(1);
    tx_word <= 16'h8700;
    frames(1);
    check({16'h0000, rx_word}, 32'h00008BA0);
  endtask : t_serial_ctrl
  task automatic t_data();
    tx_word <= 16'h7FFF;
    apb(1'b1, sdc_pkg::SDC_OFF_CTRL_A, 32'h00000001);
    frames(5);
    check({16'h0000, rx_word}, 32'h00003FFF);
    rd_chk(sdc_pkg::SDC_OFF_ADC, 32'h00003FFF);
    status_chk(16'h7FFF);
    tx_word <= 16'h8000;
    frames(2);
    status_chk(16'h8000);
    apb(1'b1, sdc_pkg::SDC_OFF_CTRL_E, 32'h00000020);
    repeat (16) @(posedge pclk);
    check({31'h0, dac_bit}, 32'h00000000);
  endtask : t_data
  task automatic t_mixed();
    tx_word <= 16'h1234;
    apb(1'b1, sdc_pkg::SDC_OFF_CTRL_A, 32'h00000003);
    frames(2);
    check({16'h0000, rx_word}, 32'h00003FFF);
    status_chk(16'h2468);
    tx_word <= 16'h8350;
    frames(2);
    check({28'h0, out_mute, out_gain_sel}, 32'h00000005);
    status_chk(16'h2468);
  endtask : t_mixed
  // ********
  // Sequence and verdict
  // ********
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_rates();
    t_serial_ctrl();
    t_data();
    t_mixed();
    tally_and_finish();
  end
endmodule : sdc_codec_test
